// ---- ivm_pkg.sv ----
/*
 * Shared constants and types for the interrupt vector map and the
 * data-space decoder of a small 8-bit controller.
 * Assumes a single processor clock and a synchronous, active-high reset.
 */
package ivm_pkg;

   // ****************************************************************
   // Vector numbering
   // ****************************************************************
   localparam int unsigned VEC_COUNT = 32;
   localparam logic [4:0] VEC_RESET          = 5'h00;
   localparam logic [4:0] VEC_SCAN_NMI       = 5'h01;
   localparam logic [4:0] VEC_VOLT_MON       = 5'h02;
   localparam logic [4:0] VEC_PORT_A         = 5'h03;
   localparam logic [4:0] VEC_PORT_B         = 5'h04;
   localparam logic [4:0] VEC_PORT_C         = 5'h05;
   localparam logic [4:0] VEC_RT_COUNTER     = 5'h06;
   localparam logic [4:0] VEC_PERIODIC       = 5'h07;
   localparam logic [4:0] VEC_TMRA_OVF       = 5'h08;
   localparam logic [4:0] VEC_TMRA_HUNF      = 5'h09;
   localparam logic [4:0] VEC_TMRA_CMP0      = 5'h0A;
   localparam logic [4:0] VEC_TMRA_CMP1      = 5'h0B;
   localparam logic [4:0] VEC_TMRA_CMP2      = 5'h0C;
   localparam logic [4:0] VEC_TMRB           = 5'h0D;
   localparam logic [4:0] VEC_COMPARATOR     = 5'h11;
   localparam logic [4:0] VEC_CONV_RESULT    = 5'h14;
   localparam logic [4:0] VEC_CONV_WINDOW    = 5'h15;
   localparam logic [4:0] VEC_TW_TARGET      = 5'h18;
   localparam logic [4:0] VEC_TW_CONTROLLER  = 5'h19;
   localparam logic [4:0] VEC_SER_PERIPH     = 5'h1A;
   localparam logic [4:0] VEC_SER_RX_DONE    = 5'h1B;
   localparam logic [4:0] VEC_SER_DATA_EMPTY = 5'h1C;
   localparam logic [4:0] VEC_SER_TX_DONE    = 5'h1D;
   localparam logic [4:0] VEC_NVM_READY      = 5'h1E;

   // Vectors that own a flag; reset, 14..16, 18, 19, 22, 23, 31 have none.
   localparam logic [31:0] VEC_SOURCE_MASK = 32'h7F32_3FFE;
   localparam logic [31:0] VEC_RESET_VALUE = 32'h0000_0000;

   // ****************************************************************
   // Data-space map, in ascending base order
   // ****************************************************************
   localparam int unsigned PERIPH_COUNT = 32;
   localparam logic [15:0] PERIPH_BASE [PERIPH_COUNT] = '{
      16'h0000, 16'h0004, 16'h0008, 16'h001C, 16'h0030, 16'h0040,
      16'h0050, 16'h0060, 16'h0080, 16'h00A0, 16'h0100, 16'h0110,
      16'h0120, 16'h0140, 16'h0180, 16'h01C0, 16'h0200, 16'h0400,
      16'h0420, 16'h0440, 16'h0600, 16'h0680, 16'h0800, 16'h0810,
      16'h0820, 16'h0A00, 16'h0A40, 16'h0F00, 16'h1000, 16'h1100,
      16'h1280, 16'h1300};
   // End of the mapped peripheral and memory-mapped region.
   localparam logic [15:0] DECODE_LIMIT = 16'h1800;

   // Peripheral indices into PERIPH_BASE.
   localparam logic [4:0] SEL_SYSTEM_CONFIG = 5'h1B;

   // Silicon revision register inside the system configuration block.
   localparam logic [15:0] SILICON_REVISION_OFFSET = 16'h0001;
   localparam logic [7:0]  READ_RESET_VALUE        = 8'h00;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic scan_checker_nmi;
      logic voltage_level_monitor_irq;
      logic port_a_pin_irq;
      logic port_b_pin_irq;
      logic port_c_pin_irq;
      logic realtime_counter_irq;
      logic periodic_timer_irq;
      logic timer_a_overflow_irq;
      logic timer_a_high_underflow_irq;
      logic timer_a_compare0_irq;
      logic timer_a_compare1_irq;
      logic timer_a_compare2_irq;
      logic timer_b_irq;
      logic comparator_irq;
      logic converter_result_irq;
      logic converter_window_irq;
      logic two_wire_target_irq;
      logic two_wire_controller_irq;
      logic serial_periph_irq;
      logic serial_rx_complete_irq;
      logic serial_data_empty_irq;
      logic serial_tx_complete_irq;
      logic nvm_ready_irq;
   } ivm_sources_t;

   typedef struct packed {
      logic        hit;
      logic [4:0]  sel;
      logic [15:0] offset;
   } ivm_decode_t;

endpackage : ivm_pkg

// ---- ivm_addr_decoder.sv ----
/*
 * Data-space address decoder: picks the peripheral whose base is the
 * highest one not above the address and reports the offset into it.
 * Assumes the address comes from logic on the same clock.
 */
`timescale 1ns/100ps

module ivm_addr_decoder
(
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Access request.
   input  wire logic [15:0]      addr_i,
   input  wire logic             strobe_i,
   // Registered decode result.
   output ivm_pkg::ivm_decode_t  dec_o,
   output logic                  dec_valid_o
);

   typedef struct packed {
      ivm_pkg::ivm_decode_t dec;
      logic                 valid;
   } ivm_dec_state_t;

   ivm_dec_state_t state_q;
   ivm_dec_state_t state_d;

   // Highest base not above the address; the table is ascending so the
   // last match wins.
   function automatic ivm_pkg::ivm_decode_t decode(input logic [15:0] addr);
      ivm_pkg::ivm_decode_t r;
      r = '0;
      r.hit = (addr < ivm_pkg::DECODE_LIMIT);
      for (int i = 0; i < ivm_pkg::PERIPH_COUNT; i++)
      begin
         if (addr >= ivm_pkg::PERIPH_BASE[i])
         begin
            r.sel    = 5'(i);
            r.offset = addr - ivm_pkg::PERIPH_BASE[i];
         end
      end
      if (!r.hit)
      begin
         r.sel    = '0;
         r.offset = '0;
      end
      return r;
   endfunction : decode

   // Decode is registered so the read path sees a clean select.
   always_comb
   begin
      state_d       = state_q;
      state_d.valid = strobe_i;
      if (strobe_i)
      begin
         state_d.dec = decode(addr_i);
      end
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign dec_o       = state_q.dec;
   assign dec_valid_o = state_q.valid;

endmodule : ivm_addr_decoder

// ---- ivm_irq_vector_map.sv ----
/*
 * Interrupt flag, enable and request logic for every vector with a source, plus the
 * data-space decode and the read-only silicon revision register.
 * Assumes peripheral events and processor accesses share clk_i.
 */
// Summary of operation
// - Peripheral event sets its sticky flag.
// - Request when enable and flag both set.
// - Request holds until flag, enable or global enable clears.
// - No request without global interrupt enable.
// - Each vector belongs to one peripheral.
// - Vectors 0-2: reset, scan NMI, voltage.
// - Vectors 3-7: ports A-C, counter, periodic.
// - Vectors 8-12: first timer sources in order.
// - 13 second timer, 17 comparator; gaps empty.
// - 20 converter result, 21 converter window.
// - 24-30: two-wire, SPI, serial, NVM.
// - Virtual ports, GPIO, processor low bases.
// - Interrupt, scan, counter, events, logic, mux.
// - Port blocks, converter, comparator bases.
// - Serial, two-wire and SPI bases.
// - Timers and system configuration bases.
// - NVM, signature, fuses, user row bases.
// - Processor can read silicon revision.
// - Revision at offset 0x01, 8-bit read-only.
`timescale 1ns/100ps

module ivm_irq_vector_map
#(
   // Silicon revision, counted from zero; value arbitrary.
   parameter logic [7:0] SILICON_REVISION = 8'h00
)
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Peripheral event pulses.
   input  ivm_pkg::ivm_sources_t     src_event_i,
   // Flag register write, one clears.
   input  wire logic                 flag_clear_wr_i,
   input  wire logic [31:0]          flag_clear_data_i,
   // Enable register write.
   input  wire logic                 enable_wr_i,
   input  wire logic [31:0]          enable_data_i,
   // Global interrupt enable from the processor status.
   input  wire logic                 global_enable_i,
   // Processor read access.
   input  wire logic [15:0]          rd_addr_i,
   input  wire logic                 rd_strobe_i,
   // Interrupt requests per vector and status.
   output logic [31:0]               irq_req_o,
   output logic                      irq_any_o,
   output logic                      irq_nmi_o,
   output logic [4:0]                irq_lowest_o,
   output logic [31:0]               int_flag_register_o,
   output logic [31:0]               int_enable_register_o,
   // Read answer and decode.
   output logic [7:0]                rd_data_o,
   output logic                      rd_valid_o,
   output ivm_pkg::ivm_decode_t      rd_sel_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0]          flags;
      logic [31:0]          enables;
      logic [31:0]          req;
      logic                 any;
      logic                 nmi;
      logic [4:0]           lowest;
      logic [7:0]           rdata;
      logic                 rvalid;
      ivm_pkg::ivm_decode_t rsel;
   } ivm_state_t;

   ivm_state_t state_q;
   ivm_state_t state_d;

   // Decoder outputs.
   ivm_pkg::ivm_decode_t dec;
   logic                 dec_valid;

   // Event pulses laid out by vector number.
   logic [31:0]          event_vec;

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Place each named source on its fixed vector. Every vector has at
   // most one driver here, so a vector never carries two peripherals.
   function automatic logic [31:0] map_sources(input ivm_pkg::ivm_sources_t s);
      logic [31:0] v;
      v = '0;
      v[ivm_pkg::VEC_SCAN_NMI]       = s.scan_checker_nmi;
      v[ivm_pkg::VEC_VOLT_MON]       = s.voltage_level_monitor_irq;
      v[ivm_pkg::VEC_PORT_A]         = s.port_a_pin_irq;
      v[ivm_pkg::VEC_PORT_B]         = s.port_b_pin_irq;
      v[ivm_pkg::VEC_PORT_C]         = s.port_c_pin_irq;
      v[ivm_pkg::VEC_RT_COUNTER]     = s.realtime_counter_irq;
      v[ivm_pkg::VEC_PERIODIC]       = s.periodic_timer_irq;
      v[ivm_pkg::VEC_TMRA_OVF]       = s.timer_a_overflow_irq;
      v[ivm_pkg::VEC_TMRA_HUNF]      = s.timer_a_high_underflow_irq;
      v[ivm_pkg::VEC_TMRA_CMP0]      = s.timer_a_compare0_irq;
      v[ivm_pkg::VEC_TMRA_CMP1]      = s.timer_a_compare1_irq;
      v[ivm_pkg::VEC_TMRA_CMP2]      = s.timer_a_compare2_irq;
      v[ivm_pkg::VEC_TMRB]           = s.timer_b_irq;
      v[ivm_pkg::VEC_COMPARATOR]     = s.comparator_irq;
      v[ivm_pkg::VEC_CONV_RESULT]    = s.converter_result_irq;
      v[ivm_pkg::VEC_CONV_WINDOW]    = s.converter_window_irq;
      v[ivm_pkg::VEC_TW_TARGET]      = s.two_wire_target_irq;
      v[ivm_pkg::VEC_TW_CONTROLLER]  = s.two_wire_controller_irq;
      v[ivm_pkg::VEC_SER_PERIPH]     = s.serial_periph_irq;
      v[ivm_pkg::VEC_SER_RX_DONE]    = s.serial_rx_complete_irq;
      v[ivm_pkg::VEC_SER_DATA_EMPTY] = s.serial_data_empty_irq;
      v[ivm_pkg::VEC_SER_TX_DONE]    = s.serial_tx_complete_irq;
      v[ivm_pkg::VEC_NVM_READY]      = s.nvm_ready_irq;
      return v & ivm_pkg::VEC_SOURCE_MASK;
   endfunction : map_sources

   // Lowest-numbered set bit; zero when nothing is set. This is only a
   // hint for the core, not an arbiter with levels.
   function automatic logic [4:0] lowest_set(input logic [31:0] v);
      logic [4:0] n;
      n = '0;
      for (int i = int'(ivm_pkg::VEC_COUNT) - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            n = 5'(i);
         end
      end
      return n;
   endfunction : lowest_set

   // ****************************************************************
   // Address decoder
   // ****************************************************************

   // The decoder holds the whole base table, so the map lives in one
   // place and both the read path and the select output share it.
   ivm_addr_decoder u_decoder
   (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .addr_i      (rd_addr_i),
      .strobe_i    (rd_strobe_i),
      .dec_o       (dec),
      .dec_valid_o (dec_valid)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // Events sorted onto vector positions.
   assign event_vec = map_sources(src_event_i);

   // Flags, enables, requests and the read path.
   always_comb
   begin
      logic [31:0] flags_n;
      logic [31:0] req_n;
      flags_n = state_q.flags;
      req_n   = '0;
      state_d = state_q;

      // A written one clears a flag, but an event in the same cycle
      // wins so that no interrupt is ever dropped.
      if (flag_clear_wr_i)
      begin
         flags_n = flags_n & ~flag_clear_data_i;
      end
      flags_n       = flags_n | event_vec;
      state_d.flags = flags_n & ivm_pkg::VEC_SOURCE_MASK;

      // Enables only exist where a vector has a source.
      if (enable_wr_i)
      begin
         state_d.enables = enable_data_i & ivm_pkg::VEC_SOURCE_MASK;
      end

      // Requests are a pure level of flag and enable: they fall only
      // when a flag, an enable or the global enable falls, never on a timer.
      req_n = state_d.flags & state_d.enables;
      if (!global_enable_i)
      begin
         req_n = '0;
      end
      state_d.req    = req_n;
      state_d.any    = |req_n;
      state_d.nmi    = req_n[ivm_pkg::VEC_SCAN_NMI];
      state_d.lowest = lowest_set(req_n);

      // Read answer one cycle after the decode; the revision register is
      // the only readable location, everything else reads zero.
      state_d.rvalid = dec_valid;
      if (dec_valid)
      begin
         state_d.rsel  = dec;
         state_d.rdata = ivm_pkg::READ_RESET_VALUE;
         if (dec.hit
             && dec.sel == ivm_pkg::SEL_SYSTEM_CONFIG
             && dec.offset == ivm_pkg::SILICON_REVISION_OFFSET)
         begin
            state_d.rdata = SILICON_REVISION;
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Everything resets clear; the revision is a constant and needs none.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_q         <= '0;
         state_q.flags   <= ivm_pkg::VEC_RESET_VALUE;
         state_q.enables <= ivm_pkg::VEC_RESET_VALUE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // All outputs are register bits of the state.
   assign irq_req_o             = state_q.req;
   assign irq_any_o             = state_q.any;
   assign irq_nmi_o             = state_q.nmi;
   assign irq_lowest_o          = state_q.lowest;
   assign int_flag_register_o   = state_q.flags;
   assign int_enable_register_o = state_q.enables;
   assign rd_data_o             = state_q.rdata;
   assign rd_valid_o            = state_q.rvalid;
   assign rd_sel_o              = state_q.rsel;

endmodule : ivm_irq_vector_map

// ---- ivm_irq_vector_map_monitor.sv ----
/*
 * Concurrent checks on the ports of the interrupt vector map.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module ivm_irq_vector_map_monitor
#(
   parameter logic [7:0] SILICON_REVISION = 8'h00
)
(
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Stimulus seen by the block.
   input  ivm_pkg::ivm_sources_t     src_event_i,
   input  wire logic                 flag_clear_wr_i,
   input  wire logic [31:0]          flag_clear_data_i,
   input  wire logic                 enable_wr_i,
   input  wire logic [31:0]          enable_data_i,
   input  wire logic                 global_enable_i,
   input  wire logic [15:0]          rd_addr_i,
   input  wire logic                 rd_strobe_i,
   // Answers of the block.
   input  wire logic [31:0]          irq_req_o,
   input  wire logic                 irq_any_o,
   input  wire logic                 irq_nmi_o,
   input  wire logic [31:0]          int_flag_register_o,
   input  wire logic [31:0]          int_enable_register_o,
   input  wire logic [7:0]           rd_data_o,
   input  wire logic                 rd_valid_o,
   input  ivm_pkg::ivm_decode_t      rd_sel_o
);
   // Vector of each source field, most significant field first.
   localparam int VMAP [23] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 17, 20, 21, 24, 25, 26, 27, 28, 29, 30};
   logic [31:0] ev_vec;

   // Events spread onto vector numbers, so flags can be compared bitwise.
   always_comb
   begin
      ev_vec = 32'h0000_0000;
      for (int k = 0; k < 23; k++)
         ev_vec[VMAP[k]] = src_event_i[22 - k];
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_req_is_and: assert property (!$past(reset_i) |-> irq_req_o == (int_flag_register_o &
      int_enable_register_o & {32{$past(global_enable_i)}})) else $error("request not flag and enable and global");
   a_flag_sets: assert property (|ev_vec |=> (int_flag_register_o & $past(ev_vec)) == $past(ev_vec))
      else $error("event did not set its flag");
   a_flag_sticky: assert property (!flag_clear_wr_i |=>
      (int_flag_register_o & $past(int_flag_register_o)) == $past(int_flag_register_o)) else $error("flag dropped");
   a_clear_works: assert property (flag_clear_wr_i |=>
      (int_flag_register_o & $past(flag_clear_data_i) & ~$past(ev_vec)) == 32'h0000_0000) else $error("clear ignored");
   a_enable_load: assert property (enable_wr_i |=>
      int_enable_register_o == ($past(enable_data_i) & ivm_pkg::VEC_SOURCE_MASK)) else $error("enable not loaded");
   a_enable_hold: assert property (!enable_wr_i |=> $stable(int_enable_register_o))
      else $error("enable changed without write");
   a_empty_vectors: assert property (((int_flag_register_o | int_enable_register_o) &
      ~ivm_pkg::VEC_SOURCE_MASK) == 32'h0000_0000) else $error("empty vector holds a bit");
   a_nmi_vector: assert property (irq_nmi_o == irq_req_o[1] && irq_any_o == (|irq_req_o))
      else $error("summary outputs wrong");
   a_read_latency: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
      rd_valid_o == $past(rd_strobe_i, 2)) else $error("read answer not two cycles after strobe");
   a_revision_read: assert property (rd_strobe_i && rd_addr_i == 16'h0F01 |-> ##2 rd_data_o == SILICON_REVISION
      && rd_sel_o.sel == ivm_pkg::SEL_SYSTEM_CONFIG && rd_sel_o.offset == 16'h0001) else $error("revision read wrong");
   a_unmapped_miss: assert property (rd_strobe_i && rd_addr_i >= 16'h1800 |-> ##2
      !rd_sel_o.hit && rd_data_o == 8'h00) else $error("unmapped read hit");

endmodule : ivm_irq_vector_map_monitor

bind ivm_irq_vector_map ivm_irq_vector_map_monitor #(.SILICON_REVISION(SILICON_REVISION)) i_ivm_irq_vector_map_monitor
   (.clk_i, .reset_i, .src_event_i, .flag_clear_wr_i, .flag_clear_data_i, .enable_wr_i, .enable_data_i,
    .global_enable_i, .rd_addr_i, .rd_strobe_i, .irq_req_o, .irq_any_o, .irq_nmi_o, .int_flag_register_o,
    .int_enable_register_o, .rd_data_o, .rd_valid_o, .rd_sel_o);

// ---- ivm_core_model.sv ----
/*
 * Behavioural processor core: writes enables, clears flags, reads bytes
 * and services requests promptly or slowly.
 * Assumes it shares clk_i with the block and drives on the falling edge.
 */
`timescale 1ns/100ps

module ivm_core_model
(
   // Clock.
   input  wire logic        clk_i,
   // Requests and read answers.
   input  wire logic        irq_any_i,
   input  wire logic [4:0]  irq_lowest_i,
   input  wire logic        rd_valid_i,
   input  wire logic [7:0]  rd_data_i,
   // Register writes, global enable and reads.
   output logic             flag_clear_wr_o,
   output logic [31:0]      flag_clear_data_o,
   output logic             enable_wr_o,
   output logic [31:0]      enable_data_o,
   output logic             global_enable_o,
   output logic [15:0]      rd_addr_o,
   output logic             rd_strobe_o
);
   // Idle strobes at time zero; data lines stay unknown until first use,
   // as on a released bus, since nothing samples them without a strobe.
   initial
   begin
      {flag_clear_wr_o, enable_wr_o, global_enable_o, rd_strobe_o} = 4'h0;
   end

   // Released data lines show the inverse so stale values never pass.
   task automatic write_enables(input logic [31:0] bits);
      @(negedge clk_i);
      enable_data_o = bits;
      enable_wr_o = 1'b1;
      @(negedge clk_i);
      enable_wr_o = 1'b0;
      enable_data_o = ~bits;
   endtask : write_enables

   // Writing one to a flag bit clears it.
   task automatic clear_flags(input logic [31:0] bits);
      @(negedge clk_i);
      flag_clear_data_o = bits;
      flag_clear_wr_o = 1'b1;
      @(negedge clk_i);
      flag_clear_wr_o = 1'b0;
      flag_clear_data_o = ~bits;
   endtask : clear_flags

   task automatic set_global(input logic v);
      @(negedge clk_i);
      global_enable_o = v;
   endtask : set_global

   // One byte read; the wait for the answer is bounded.
   task automatic read_byte(input logic [15:0] addr, output logic [7:0] data, output logic ok);
      ok = 1'b0;
      data = 8'h00;
      @(negedge clk_i);
      rd_addr_o = addr;
      rd_strobe_o = 1'b1;
      @(negedge clk_i);
      rd_strobe_o = 1'b0;
      rd_addr_o = ~addr;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(posedge clk_i);
         #1;
         ok = rd_valid_i;
         data = rd_data_i;
      end
   endtask : read_byte

   // Handler entry after a chosen delay; clears the lowest pending vector.
   task automatic service(input int delay, output logic [4:0] vec);
      for (int i = 0; i < 20 && !irq_any_i; i++)
         @(negedge clk_i);
      repeat (delay) @(negedge clk_i);
      vec = irq_lowest_i;
      clear_flags(32'h1 << irq_lowest_i);
   endtask : service

endmodule : ivm_core_model

// ---- ivm_irq_vector_map_tb.sv ----
/*
 * Self-checking testbench for the interrupt vector map.
 * Assumes the checker is bound to the block by its own file.
 */
`timescale 1ns/100ps

module ivm_irq_vector_map_tb;
   localparam logic [7:0] REV = 8'h03;
   localparam int VMAP [23] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 17, 20, 21, 24, 25, 26, 27, 28, 29, 30};
   localparam logic [15:0] BASES [32] = '{16'h0000, 16'h0004, 16'h0008, 16'h001C, 16'h0030, 16'h0040, 16'h0050,
      16'h0060, 16'h0080, 16'h00A0, 16'h0100, 16'h0110, 16'h0120, 16'h0140, 16'h0180, 16'h01C0, 16'h0200, 16'h0400,
      16'h0420, 16'h0440, 16'h0600, 16'h0680, 16'h0800, 16'h0810, 16'h0820, 16'h0A00, 16'h0A40, 16'h0F00, 16'h1000,
      16'h1100, 16'h1280, 16'h1300};

   logic                   clk_i, reset_i, fcw, enw, gen, rds, irq_any, irq_nmi, rd_valid;
   ivm_pkg::ivm_sources_t  src_event_i;
   logic [31:0]            fcd, end_data, irq_req, flags, enables;
   logic [15:0]            rda;
   logic [4:0]             lowest;
   logic [7:0]             rd_data;
   ivm_pkg::ivm_decode_t   rd_sel;
   int                     fails, checks;

   ivm_irq_vector_map #(.SILICON_REVISION(REV)) i_ivm_irq_vector_map (.clk_i(clk_i), .reset_i(reset_i),
      .src_event_i(src_event_i), .flag_clear_wr_i(fcw), .flag_clear_data_i(fcd), .enable_wr_i(enw),
      .enable_data_i(end_data), .global_enable_i(gen), .rd_addr_i(rda), .rd_strobe_i(rds), .irq_req_o(irq_req),
      .irq_any_o(irq_any), .irq_nmi_o(irq_nmi), .irq_lowest_o(lowest), .int_flag_register_o(flags),
      .int_enable_register_o(enables), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_sel_o(rd_sel));

   ivm_core_model i_ivm_core_model (.clk_i(clk_i), .irq_any_i(irq_any), .irq_lowest_i(lowest),
      .rd_valid_i(rd_valid), .rd_data_i(rd_data), .flag_clear_wr_o(fcw), .flag_clear_data_o(fcd),
      .enable_wr_o(enw), .enable_data_o(end_data), .global_enable_o(gen), .rd_addr_o(rda), .rd_strobe_o(rds));

   // 100 MHz clock.
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // One event pulse on source field k, most significant field first.
   task automatic pulse(input int k);
      @(negedge clk_i);
      src_event_i = ivm_pkg::ivm_sources_t'(23'h1 << (22 - k));
      @(negedge clk_i);
      src_event_i = '0;
   endtask : pulse

   // Every source reaches its own vector only, and clears again.
   task automatic t_vectors;
      i_ivm_core_model.write_enables(32'hFFFF_FFFF);
      check("enables", 32'h7F32_3FFE, enables);
      i_ivm_core_model.set_global(1'b1);
      for (int k = 0; k < 23; k++)
      begin
         pulse(k);
         check("request", 32'h1 << VMAP[k], irq_req);
         check("lowest", VMAP[k], {27'h0, lowest});
         check("nmi", VMAP[k] == 1, {31'h0, irq_nmi});
         i_ivm_core_model.clear_flags(32'h1 << VMAP[k]);
         check("flags", 32'h0, flags);
         check("request", 32'h0, irq_req);
      end
   endtask : t_vectors

   // Global gate, local enable, held request and slow service.
   task automatic t_gating;
      logic [4:0] vec;
      i_ivm_core_model.set_global(1'b0);
      pulse(7);
      check("flags", 32'h100, flags);
      check("request", 32'h0, irq_req);
      i_ivm_core_model.set_global(1'b1);
      @(negedge clk_i);
      check("request", 32'h100, irq_req);
      repeat (12) @(negedge clk_i);
      check("request", 32'h100, irq_req);
      fork
         i_ivm_core_model.clear_flags(32'h100);
         pulse(7);
      join
      check("flags", 32'h100, flags);
      i_ivm_core_model.write_enables(32'h0);
      check("request", 32'h0, irq_req);
      i_ivm_core_model.write_enables(32'h100);
      i_ivm_core_model.service(9, vec);
      check("vector", 32'h8, {27'h0, vec});
      check("request", 32'h0, irq_req);
   endtask : t_gating

   // Reset in mid-run drops pending flags, enables and requests.
   task automatic t_reset;
      i_ivm_core_model.write_enables(32'h2);
      pulse(0);
      check("request", 32'h2, irq_req);
      @(negedge clk_i);
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      check("reset", 32'h0, irq_req | flags | enables | {31'h0, irq_nmi});
      @(negedge clk_i);
      check("request", 32'h0, irq_req);
   endtask : t_reset

   task automatic rd_chk(input logic [15:0] a, input logic [21:0] dec, input logic [7:0] d);
      logic [7:0] got;
      logic       ok;
      i_ivm_core_model.read_byte(a, got, ok);
      check("valid", 32'h1, {31'h0, ok});
      check("decode", {10'h0, dec}, {10'h0, rd_sel});
      check("data", {24'h0, d}, {24'h0, got});
   endtask : rd_chk

   // Each base and the byte below it, revision and unmapped reads.
   task automatic t_decode;
      for (int i = 0; i < 32; i++)
      begin
         rd_chk(BASES[i], {1'b1, 5'(i), 16'h0}, 8'h00);
         if (i > 0)
            rd_chk(BASES[i] - 16'h1, {1'b1, 5'(i - 1), BASES[i] - 16'h1 - BASES[i - 1]}, 8'h00);
      end
      rd_chk(16'h0F01, {1'b1, 5'd27, 16'h0001}, REV);
      rd_chk(16'h0F02, {1'b1, 5'd27, 16'h0002}, 8'h00);
      rd_chk(16'h1800, 22'h0, 8'h00);
      rd_chk(16'hFFFF, 22'h0, 8'h00);
   endtask : t_decode

   // Main sequence: reset for eight cycles, then every scenario.
   initial
   begin
      fails = 0;
      checks = 0;
      reset_i = 1'b1;
      src_event_i = '0;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      check("reset", 32'h0, irq_req | flags | enables | {31'h0, rd_valid});
      t_vectors();
      t_gating();
      t_reset();
      t_decode();
      complete_run();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      complete_run();
   end

endmodule : ivm_irq_vector_map_tb
